// File: rtl/ple_top.sv
// programmable logic equations evaluated in a repeating device cycle
`timescale 1ns/100ps

// Functional notes
// - four inputs per equation, selectable sources
// - each input separately invertible
// - gate result passes assert/release delay
// - direct output and set-and-hold latched output
// - complement of latched output provided
// - latch cleared by selectable, invertible reset
// - reset dominates set
// - equations evaluated ascending, cycle repeats
// - equation outputs selectable as inputs
// - lower-index changes seen same cycle
// - higher-index feedback seen next cycle
module ple_top (
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire logic [ple_pkg::IN_N-1:0]   signal_in,
  input  wire logic [ple_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ple_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [ple_pkg::DATA_W-1:0] reg_rdata,
  output logic      [ple_pkg::EQ_N-1:0]   eq_direct,
  output logic      [ple_pkg::EQ_N-1:0]   eq_latched,
  output logic      [ple_pkg::EQ_N-1:0]   eq_latched_n,
  output logic                            cycle_done
);
  import ple_pkg::*;

  logic [DATA_W-1:0] cfg_reg [EQ_N];
  logic [RST_W-1:0]  rst_reg [EQ_N];
  logic [DLY_W-1:0]  on_reg  [EQ_N];
  logic [DLY_W-1:0]  off_reg [EQ_N];

  logic [IN_N-1:0]   in_meta_reg;
  logic [IN_N-1:0]   in_sync_reg;
  logic [IN_N-1:0]   in_snap_reg;
  logic [EQ_N-1:0]   dir_reg;
  logic [EQ_N-1:0]   lat_reg;
  logic [EQ_N-1:0]   lat_n_reg;
  logic              done_reg;
  logic [DATA_W-1:0] rdata_reg;

  ple_state_t        state_reg;
  logic [IDX_W-1:0]  idx_reg;

  logic [SRC_N-1:0]  src;
  logic              eval;
  logic              gate_res;
  logic              rst_act;
  logic [EQ_N-1:0]   dly_next;
  logic              dly_cur;
  logic              wr_eq;
  logic [IDX_W-1:0]  wr_idx;
  logic [IDX_W-1:0]  rd_idx;

  assign eq_direct    = dir_reg;
  assign eq_latched   = lat_reg;
  assign eq_latched_n = lat_n_reg;
  assign cycle_done   = done_reg;
  assign reg_rdata    = rdata_reg;

  assign eval    = (state_reg == PLE_ST_EVAL);
  assign dly_cur = dly_next[idx_reg];

  // outputs already updated this cycle sit beside last cycle's higher ones
  assign src = {lat_n_reg, lat_reg, dir_reg, in_snap_reg};

  // pins come from outside the clock domain
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_meta_reg <= '0;
      in_sync_reg <= '0;
    end else begin
      in_meta_reg <= signal_in;
      in_sync_reg <= in_meta_reg;
    end
  end

  // one snapshot per cycle so every equation sees the same pin state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_snap_reg <= '0;
    end else if (state_reg == PLE_ST_SNAP) begin
      in_snap_reg <= in_sync_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PLE_ST_IDLE;
      idx_reg   <= IDX_FIRST;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        PLE_ST_IDLE: begin
          state_reg <= PLE_ST_SNAP;
        end
        PLE_ST_SNAP: begin
          state_reg <= PLE_ST_EVAL;
          idx_reg   <= IDX_FIRST;
        end
        PLE_ST_EVAL: begin
          if (idx_reg == IDX_LAST) begin
            state_reg <= PLE_ST_SNAP;
            done_reg  <= 1'b1;
          end else begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        default: begin
          state_reg <= PLE_ST_IDLE;
        end
      endcase
    end
  end

  // gate of the equation currently being evaluated
  always_comb begin
    logic [DATA_W-1:0] cur;
    logic [SEL_W-1:0]  sel;
    logic              term;
    logic              all_one;
    logic              any_one;
    cur     = cfg_reg[idx_reg];
    sel     = SEL_NONE;
    term    = 1'b0;
    all_one = 1'b1;
    any_one = 1'b0;
    for (int k = 0; k < TERM_N; k++) begin
      sel = cur[CFG_SEL_LSB + k * SEL_W +: SEL_W];
      // unassigned terms are skipped, which is neutral for every gate
      if (sel < SRC_LIMIT) begin
        term    = src[sel] ^ cur[CFG_INV_LSB + k];
        all_one = all_one & term;
        any_one = any_one | term;
      end
    end
    case (ple_gate_t'(cur[CFG_GATE_LSB +: GATE_W]))
      PLE_GATE_AND:  gate_res = all_one;
      PLE_GATE_OR:   gate_res = any_one;
      PLE_GATE_NAND: gate_res = ~all_one;
      PLE_GATE_NOR:  gate_res = ~any_one;
      default:       gate_res = all_one;
    endcase
  end

  always_comb begin
    logic [SEL_W-1:0] rsel;
    rsel    = rst_reg[idx_reg][RST_SEL_LSB +: SEL_W];
    rst_act = 1'b0;
    if (rsel < SRC_LIMIT) begin
      rst_act = src[rsel] ^ rst_reg[idx_reg][RST_INV_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < EQ_N; g++) begin : g_delay
      ple_delay u_delay (
        .clock              (clock),
        .arst_n             (arst_n),
        .step               (eval && (idx_reg == IDX_W'(g))),
        .level              (gate_res),
        .assert_delay_time  (on_reg[g]),
        .release_delay_time (off_reg[g]),
        .out_next           (dly_next[g])
      );
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dir_reg <= '0;
    end else if (eval) begin
      dir_reg[idx_reg] <= dly_cur;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lat_reg   <= '0;
      lat_n_reg <= '1;
    end else if (eval) begin
      if (rst_act) begin
        lat_reg[idx_reg]   <= 1'b0;
        lat_n_reg[idx_reg] <= 1'b1;
      end else if (dly_cur) begin
        lat_reg[idx_reg]   <= 1'b1;
        lat_n_reg[idx_reg] <= 1'b0;
      end
    end
  end

  // configuration writes; a change applies from the next evaluation step
  assign wr_eq  = reg_wr && (reg_addr < ADDR_EQ_END);
  assign wr_idx = reg_addr[2 +: IDX_W];
  assign rd_idx = reg_addr[2 +: IDX_W];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < EQ_N; i++) begin
        cfg_reg[i] <= CFG_RESET;
        rst_reg[i] <= RST_RESET;
        on_reg[i]  <= DLY_RESET;
        off_reg[i] <= DLY_RESET;
      end
    end else if (wr_eq) begin
      case (reg_addr[1:0])
        WORD_CFG: cfg_reg[wr_idx] <= reg_wdata;
        WORD_RST: rst_reg[wr_idx] <= reg_wdata[RST_W-1:0];
        WORD_ON:  on_reg[wr_idx]  <= reg_wdata[DLY_W-1:0];
        WORD_OFF: off_reg[wr_idx] <= reg_wdata[DLY_W-1:0];
        default:  cfg_reg[wr_idx] <= reg_wdata;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (!reg_rd) begin
      rdata_reg <= '0;
    end else if (reg_addr < ADDR_EQ_END) begin
      case (reg_addr[1:0])
        WORD_CFG: rdata_reg <= cfg_reg[rd_idx];
        WORD_RST: rdata_reg <= {25'h0000000, rst_reg[rd_idx]};
        WORD_ON:  rdata_reg <= {16'h0000, on_reg[rd_idx]};
        WORD_OFF: rdata_reg <= {16'h0000, off_reg[rd_idx]};
        default:  rdata_reg <= '0;
      endcase
    end else if (reg_addr == ADDR_STATUS) begin
      rdata_reg <= {lat_n_reg, 8'h00, lat_reg, dir_reg};
    end else if (reg_addr == ADDR_INPUTS) begin
      rdata_reg <= {16'h0000, in_snap_reg};
    end else begin
      rdata_reg <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence snap_s;
    state_reg == PLE_ST_SNAP;
  endsequence

  sequence walk_s;
    (eval && (idx_reg == IDX_FIRST)) ##7 (eval && (idx_reg == IDX_LAST));
  endsequence

  eval_cycle_a: assert property (
    snap_s |=> walk_s ##1 snap_s)
    else $error("evaluation cycle did not walk all equations in order");

  eval_order_a: assert property (
    eval && (idx_reg != IDX_LAST) |=> eval
      && (idx_reg == IDX_W'($past(idx_reg) + 3'h1)))
    else $error("equation index did not step by one");

  reset_wins_a: assert property (
    eval && rst_act |=> !lat_reg[$past(idx_reg)])
    else $error("latch not cleared while reset active");

  latch_set_a: assert property (
    eval && !rst_act && dly_cur |=> lat_reg[$past(idx_reg)])
    else $error("latch not set by delayed result");

  latch_hold_a: assert property (
    eval && !rst_act && !dly_cur |=> lat_reg[$past(idx_reg)]
      == $past(lat_reg[idx_reg]))
    else $error("latch changed without set or reset");

  latch_inverse_a: assert property (
    lat_n_reg == ~lat_reg)
    else $error("inverted latched output not complement");

  direct_follow_a: assert property (
    eval |=> dir_reg[$past(idx_reg)] == $past(dly_cur))
    else $error("direct output did not take delayed result");

  snap_stable_a: assert property (
    eval |=> $stable(in_snap_reg))
    else $error("input snapshot changed during evaluation");

  done_pulse_a: assert property (
    eval && (idx_reg == IDX_LAST) |=> done_reg ##1 !done_reg)
    else $error("cycle done pulse wrong");

  status_read_a: assert property (
    reg_rd && (reg_addr == ADDR_STATUS) |=> reg_rdata
      == {$past(lat_n_reg), 8'h00, $past(lat_reg), $past(dir_reg)})
    else $error("status read data wrong");
endmodule

// File: rtl/ple_pkg.sv
// constants and types for the programmable logic equation block
package ple_pkg;
  localparam int EQ_N   = 8;
  localparam int IN_N   = 16;
  localparam int TERM_N = 4;
  localparam int SEL_W  = 6;
  localparam int IDX_W  = 3;
  localparam int DLY_W  = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SRC_N  = IN_N + 3 * EQ_N;

  // source numbering: pins, then direct, latched, inverted latched outputs
  localparam logic [SEL_W-1:0] SRC_DIR   = 6'h10;
  localparam logic [SEL_W-1:0] SRC_LAT   = 6'h18;
  localparam logic [SEL_W-1:0] SRC_LATN  = 6'h20;
  localparam logic [SEL_W-1:0] SRC_LIMIT = 6'h28;
  localparam logic [SEL_W-1:0] SEL_NONE  = 6'h3f;

  // equation configuration word
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_INV_LSB  = 24;
  localparam int CFG_GATE_LSB = 28;
  localparam int GATE_W       = 2;
  // reset selection word
  localparam int RST_SEL_LSB  = 0;
  localparam int RST_INV_BIT  = 6;
  localparam int RST_W        = 7;

  // register map, word addresses
  localparam logic [1:0]        WORD_CFG    = 2'h0;
  localparam logic [1:0]        WORD_RST    = 2'h1;
  localparam logic [1:0]        WORD_ON     = 2'h2;
  localparam logic [1:0]        WORD_OFF    = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_EQ_END = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_INPUTS = 8'h21;

  // reset values: terms and reset input unassigned, and gate, no delay
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h00ffffff;
  localparam logic [RST_W-1:0]  RST_RESET = 7'h3f;
  localparam logic [DLY_W-1:0]  DLY_RESET = 16'h0000;

  localparam logic [IDX_W-1:0]  IDX_FIRST = 3'h0;
  localparam logic [IDX_W-1:0]  IDX_LAST  = 3'h7;

  typedef enum logic [GATE_W-1:0] {
    PLE_GATE_AND  = 2'h0,
    PLE_GATE_OR   = 2'h1,
    PLE_GATE_NAND = 2'h2,
    PLE_GATE_NOR  = 2'h3
  } ple_gate_t;

  // gray order along idle -> snapshot -> evaluate
  typedef enum logic [1:0] {
    PLE_ST_IDLE = 2'b00,
    PLE_ST_SNAP = 2'b01,
    PLE_ST_EVAL = 2'b11
  } ple_state_t;
endpackage

// File: rtl/ple_delay.sv
// assert and release delay stage of one logic equation
`timescale 1ns/100ps
module ple_delay (
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  input  wire logic                      step,
  input  wire logic                      level,
  input  wire logic [ple_pkg::DLY_W-1:0] assert_delay_time,
  input  wire logic [ple_pkg::DLY_W-1:0] release_delay_time,
  output logic                           out_next
);
  import ple_pkg::*;

  logic             state_reg;
  logic [DLY_W-1:0] cnt_reg;
  logic [DLY_W-1:0] limit;
  logic             expire;

  // times count in evaluation cycles; zero means no delay
  assign limit  = level ? assert_delay_time : release_delay_time;
  assign expire = (cnt_reg >= limit);

  always_comb begin
    out_next = state_reg;
    if (step && (level != state_reg) && expire) begin
      out_next = level;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= 1'b0;
    end else if (step) begin
      state_reg <= out_next;
    end
  end

  // counter restarts whenever the level returns to the held state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= DLY_RESET;
    end else if (step) begin
      if ((level == state_reg) || expire) begin
        cnt_reg <= DLY_RESET;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  hold_no_step_a: assert property (
    !step |=> $stable(state_reg))
    else $error("delay output moved without an evaluation step");

  zero_delay_a: assert property (
    step && (assert_delay_time == DLY_RESET) && level |=> state_reg)
    else $error("zero assert delay did not follow at once");

  early_assert_a: assert property (
    step && level && !state_reg && (cnt_reg < assert_delay_time)
      |=> !state_reg)
    else $error("output asserted before its delay elapsed");
endmodule

// File: tb/ple_src.sv
// far-side model: protection, breaker and module signal sources
`timescale 1ns/100ps
module ple_src (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic [ple_pkg::IN_N-1:0] level_req,
  output logic      [ple_pkg::IN_N-1:0] signal_in
);
  import ple_pkg::*;
  // levels move only just after an edge, as a real source would
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      signal_in <= '0;
    end else begin
      signal_in <= level_req;
    end
  end
endmodule

// File: tb/tb_top.sv
// self-checking testbench for the logic equation block
`timescale 1ns/100ps
module tb_top;
  import ple_pkg::*;
  logic              clock = 1'b0;
  logic              arst_n;
  logic [IN_N-1:0]   level_req;
  logic [IN_N-1:0]   signal_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [EQ_N-1:0]   eq_direct;
  logic [EQ_N-1:0]   eq_latched;
  logic [EQ_N-1:0]   eq_latched_n;
  logic              cycle_done;
  logic [DATA_W-1:0] d;
  int                fails = 0;
  int                check_count = 0;

  always #4 clock = ~clock;

  ple_src src (.clock(clock), .arst_n(arst_n), .level_req(level_req),
    .signal_in(signal_in));
  ple_top dut (.clock(clock), .arst_n(arst_n), .signal_in(signal_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eq_direct(eq_direct),
    .eq_latched(eq_latched), .eq_latched_n(eq_latched_n),
    .cycle_done(cycle_done));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic hang(string n);
    fails++;
    $display("[ERR] %s expected event seen timeout", n);
    wrap_up();
  endtask

  function automatic logic [7:0] adr(int n, int k);
    return 8'(4 * n + k);
  endfunction

  function automatic logic [31:0] cfg(logic [5:0] s0, logic [5:0] s1,
                                      logic [3:0] inv, logic [1:0] g);
    return {2'h0, g, inv, SEL_NONE, SEL_NONE, s1, s0};
  endfunction

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic rd(logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic set_in(int i, logic v);
    @(posedge clock);
    level_req[i] <= v;
  endtask

  task automatic wait_done(int cnt);
    int t;
    repeat (cnt) begin
      t = 0;
      do begin
        @(posedge clock);
        #1 t++;
      end while (cycle_done !== 1'b1 && t < 30);
      if (t >= 30) hang("cycle_done");
    end
  endtask

  task automatic wait_eq(int i, logic v);
    int t;
    t = 0;
    while (eq_direct[i] !== v && t < 60) begin
      @(posedge clock);
      #1 t++;
    end
    if (t >= 60) hang("eq_direct");
  endtask

  task automatic t_reset();
    wait_done(2);
    rd(ADDR_STATUS);
    // empty and gate with no terms gives 1, latches set with no reset
    check("status", d & 32'hff00ffff, 32'h0000ffff);
    rd(adr(0, 0));
    check("cfg reset", d, CFG_RESET);
    rd(adr(0, 1));
    check("rst reset", d, 32'(RST_RESET));
    wr(8'h30, 32'hffffffff);
    rd(8'h30);
    check("unmapped", d, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_gates();
    logic a, b, e;
    for (int g = 0; g < 4; g++) begin
      wr(adr(0, 0), cfg(6'h00, 6'h01, 4'h2, 2'(g)));
      for (int p = 0; p < 4; p++) begin
        set_in(0, p[0]);
        set_in(1, p[1]);
        wait_done(3);
        a = p[0];
        b = ~p[1];
        e = (g == 0) ? (a & b) : (g == 1) ? (a | b) :
            (g == 2) ? ~(a & b) : ~(a | b);
        check("gate out", 32'(eq_direct[0]), 32'(e));
      end
    end
    $display("test gates done");
  endtask

  task automatic t_latch();
    wr(adr(1, 0), cfg(6'h02, SEL_NONE, 4'h0, 2'h0));
    wr(adr(1, 1), 32'h03);
    set_in(3, 1'b1);
    wait_done(3);
    check("latch clr", 32'(eq_latched[1]), 32'h0);
    check("latch n", 32'(eq_latched_n[1]), 32'h1);
    set_in(3, 1'b0);
    set_in(2, 1'b1);
    wait_done(3);
    check("latch set", 32'(eq_latched[1]), 32'h1);
    set_in(2, 1'b0);
    wait_done(3);
    check("latch hold", 32'({eq_latched[1], eq_direct[1]}), 32'h2);
    set_in(2, 1'b1);
    set_in(3, 1'b1);
    wait_done(3);
    check("rst wins", 32'({eq_latched[1], eq_direct[1]}), 32'h1);
    wr(adr(1, 1), 32'h43);
    set_in(3, 1'b0);
    wait_done(3);
    check("rst inv", 32'(eq_latched[1]), 32'h0);
    set_in(3, 1'b1);
    wait_done(3);
    check("rst inv off", 32'(eq_latched[1]), 32'h1);
    $display("test latch done");
  endtask

  task automatic t_cascade();
    wr(adr(3, 0), cfg(6'h04, SEL_NONE, 4'h0, 2'h0));
    wr(adr(4, 0), cfg(SRC_DIR + 6'h3, SEL_NONE, 4'h0, 2'h0));
    wr(adr(2, 0), cfg(SRC_DIR + 6'h3, SEL_NONE, 4'h0, 2'h0));
    wr(adr(7, 0), cfg(SRC_LATN + 6'h1, SEL_NONE, 4'h1, 2'h0));
    wait_done(3);
    check("casc idle", 32'(eq_direct[2]), 32'h0);
    // eq1 latch is set here, so the inverted complement reads 1
    check("latn src", 32'(eq_direct[7]), 32'h1);
    set_in(4, 1'b1);
    wait_eq(3, 1'b1);
    wait_done(1);
    check("casc up", 32'({eq_direct[4], eq_direct[2]}), 32'h2);
    wait_done(1);
    check("casc down", 32'(eq_direct[2]), 32'h1);
    $display("test cascade done");
  endtask

  // evaluations counted from the undelayed reference on eq6
  task automatic lag(logic v, int dly);
    int n;
    n = 0;
    wait_eq(6, v);
    while (eq_direct[5] !== v && n < 6) begin
      wait_done(1);
      n++;
    end
    check("delay lag", 32'(n), 32'(dly + 1));
  endtask

  task automatic t_delay();
    wr(adr(5, 0), cfg(6'h05, SEL_NONE, 4'h0, 2'h0));
    wr(adr(5, 2), 32'h2);
    wr(adr(5, 3), 32'h1);
    wr(adr(6, 0), cfg(6'h05, SEL_NONE, 4'h0, 2'h0));
    wait_done(3);
    set_in(5, 1'b1);
    lag(1'b1, 2);
    set_in(5, 1'b0);
    lag(1'b0, 1);
    $display("test delay done");
  endtask

  // pins 0..4 all high here; term 3 inverted reaches all four slots
  task automatic t_four();
    wr(adr(0, 0), {2'h0, 2'h0, 4'h8, 6'h03, 6'h02, 6'h01, 6'h00});
    wait_done(3);
    check("four terms", 32'(eq_direct[0]), 32'h0);
    set_in(3, 1'b0);
    wait_done(3);
    check("four inv", 32'(eq_direct[0]), 32'h1);
    rd(ADDR_INPUTS);
    check("inputs", d, 32'h00000017);
    $display("test four done");
  endtask

  initial begin
    level_req = '0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    arst_n    = 1'b0;
    repeat (3) @(posedge clock);
    #1 check("rst latn", 32'(eq_latched_n), 32'hff);
    check("rst direct", 32'(eq_direct), 32'h0);
    @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_gates();
    t_latch();
    t_cascade();
    t_delay();
    t_four();
    wrap_up();
  end
endmodule
